// ===== bench/mpwdp_core_model.sv
`timescale 1ns/1ps
// ****************************************
// Core-side sender of pseudowire packets.
// ****************************************
module mpwdp_core_model (
  input  wire        ref_clk,
  input  wire        in_ready,
  output logic       in_valid,
  output logic [7:0] in_data,
  output logic       in_sop,
  output logic       in_eop,
  output logic [4:0] in_pw_type
);
  logic [7:0] byte_q[$];
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_sop = 1'b0;
    in_eop = 1'b0;
    in_pw_type = 5'h01;
  end
  // Sends one packet; any start sequence value is legal, so the caller picks it.
  task automatic send(input logic [31:0] ses, input logic [7:0] sub0,
      input logic [15:0] seq, input int nb, input logic [12:0] transport_packet_identifier,
      input logic [4:0] pw, input logic udp, input logic [15:0] tv);
    int i;
    byte_q = {};
    if (udp) begin
      repeat (8) byte_q.push_back(8'h00);
      byte_q = {byte_q, tv[15:8], tv[7:0], 8'h00, 8'h00};
    end
    byte_q = {byte_q, ses[31:24], ses[23:16], ses[15:8], ses[7:0]};
    byte_q = {byte_q, sub0, 8'h00, seq[15:8], seq[7:0]};
    byte_q.push_back(8'h47);
    byte_q.push_back({3'b000, transport_packet_identifier[12:8]});
    byte_q.push_back(transport_packet_identifier[7:0]);
    // No filler anywhere; the caller keeps within seven segments.
    for (i = 3; i < nb; i++)
      byte_q.push_back(i[7:0]);
    in_pw_type <= pw;
    foreach (byte_q[k]) begin
      in_valid <= 1'b1;
      in_data <= byte_q[k];
      in_sop <= (k == 0);
      in_eop <= (k == byte_q.size() - 1);
      // The byte stands until an edge that samples ready high takes it.
      do begin
        @(posedge ref_clk);
      end while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    in_sop <= 1'b0;
    in_eop <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule

// ===== bench/mpwdp_parser_assertions.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the parser.
// ****************************************
module mpwdp_checker (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       in_valid,
  input wire       in_ready,
  input wire       in_sop,
  input wire       in_eop,
  input wire       out_valid,
  input wire       out_sop,
  input wire       out_eop,
  input wire       teardown_req,
  input wire       seq_loss
);
  logic [7:0] seg_q;
  logic [7:0] seg_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Byte position inside the output segment, so framing slips show.
  always @* seg_d = !out_valid ? seg_q : (out_eop ? 8'h00 : seg_q + 8'h01);
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) seg_q <= 8'h00;
    else seg_q <= seg_d;
  AST_SEG_LEN: assert property (out_valid && seg_q == 8'hbb |-> out_eop)
    else $error("segment runs past 188 bytes");
  AST_SEG_SOP: assert property (out_valid |-> out_sop == (seg_q == 8'h00))
    else $error("segment start misplaced");
  AST_EOP_NEXT: assert property (out_eop |=> !out_valid || out_sop)
    else $error("byte after segment end is not a start");
  AST_TD_CAUSE: assert property (teardown_req |-> $past(in_valid && in_sop))
    else $error("teardown without a packet start");
  AST_TD_PULSE: assert property (teardown_req |=> !teardown_req)
    else $error("teardown longer than one cycle");
  AST_LOSS_CAUSE: assert property (seq_loss |-> $past(in_valid && in_ready))
    else $error("loss flag without a taken byte");
  AST_LOSS_PULSE: assert property (seq_loss |=> !seq_loss)
    else $error("loss flag longer than one cycle");
  AST_DRAIN: assert property ($fell(in_ready) |-> $past(in_valid && in_eop)
    && !in_ready ##1 !in_ready [*2] ##1 in_ready)
    else $error("drain window not three cycles after end");
  COV_TD: cover property (teardown_req);
  COV_LOSS: cover property (seq_loss);
  COV_FULL: cover property (out_eop && seg_q == 8'hbb);
endmodule

bind mpwdp_parser mpwdp_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .in_valid(in_valid), .in_ready(in_ready), .in_sop(in_sop), .in_eop(in_eop),
  .out_valid(out_valid), .out_sop(out_sop), .out_eop(out_eop),
  .teardown_req(teardown_req), .seq_loss(seq_loss));

// ===== bench/test_mpeg_pseudowire_data_parser.sv
`timescale 1ns/1ps
// ****************************************
// Testbench for the parser.
// ****************************************
module test_mpeg_pseudowire_data_parser;
  localparam logic [31:0] ses_id = 32'h1234_5678;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready, pslverr, in_valid, in_ready, in_sop, in_eop;
  wire  [7:0]  in_data, out_data;
  wire  [4:0]  in_pw_type;
  wire         out_valid, out_sop, out_eop, teardown_req, seq_loss;
  int          fail_count = 0, checks_done = 0;
  int          n_out, n_sop, n_eop, n_td, n_loss;
  logic [7:0]  b0;

  mpwdp_parser uut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_data, .in_sop, .in_eop,
    .in_pw_type, .out_valid, .out_data, .out_sop, .out_eop, .teardown_req, .seq_loss);
  mpwdp_core_model core (.ref_clk, .in_ready, .in_valid, .in_data, .in_sop, .in_eop,
    .in_pw_type);

  always #50 ref_clk = ~ref_clk;
  // Tallies outputs; registered outputs still hold their pre-edge values here.
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1) begin
      if (n_out == 0) b0 = out_data;
      n_out++;
      n_sop += (out_sop === 1'b1);
      n_eop += (out_eop === 1'b1);
    end
    n_td += (teardown_req === 1'b1);
    n_loss += (seq_loss === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; an edge passes first so strobes never toggle twice at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask
  // Sends one packet and lets the three drain cycles and output latency pass.
  task automatic pkt(input logic [31:0] ses, input logic [7:0] sub0,
      input logic [15:0] seq, input int nb, input logic [12:0] transport_packet_identifier = 13'h0100,
      input logic [4:0] pw = 5'h01, input logic udp = 1'b0, input logic [15:0] tv = 16'h0003);
    n_out = 0;
    n_sop = 0;
    n_eop = 0;
    n_td = 0;
    n_loss = 0;
    core.send(ses, sub0, seq, nb, transport_packet_identifier, pw, udp, tv);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic e;
    rreg(8'h00, 32'h0000_010c);
    rreg(8'h04, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000, d, e);
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0001);
    wreg(8'h04, ses_id);
    pkt(ses_id, 8'h40, 16'h0000, 188);
    chk("off", n_out, 0);
    wreg(8'h00, 32'h0000_010d);
    rreg(8'h04, ses_id);
  endtask
  // Seven full segments with the reserved bit set must all pass.
  task automatic t_fwd;
    pkt(ses_id, 8'h48, 16'h0064, 1316);
    chk("bytes", n_out, 1316);
    chk("sops", n_sop, 7);
    chk("eops", n_eop, 7);
    chk("first", b0, 8'h47);
    rreg(8'h0c, 32'h0000_0001);
  endtask
  task automatic t_null;
    pkt(ses_id, 8'h40, 16'h0065, 376, 13'h1fff);
    chk("bytes", n_out, 188);
    chk("first", b0, 8'hbc);
    rreg(8'h18, 32'h0000_0001);
  endtask
  task automatic t_seq;
    pkt(ses_id, 8'h40, 16'h0066, 100);
    chk("loss", n_loss, 0);
    chk("tail", n_out, 100);
    chk("eops", n_eop, 1);
    pkt(ses_id, 8'h40, 16'h00c8, 188);
    chk("loss", n_loss, 1);
    pkt(ses_id, 8'h00, 16'h0001, 188);
    chk("loss", n_loss, 0);
    rreg(8'h14, 32'h0000_0001);
  endtask
  // Each broken sublayer, session and type is dropped without output.
  task automatic t_drop;
    logic [7:0] subs [5] = '{8'h80, 8'h50, 8'h60, 8'h70, 8'h43};
    foreach (subs[k]) begin
      pkt(ses_id, subs[k], 16'h0000, 188);
      chk("drop", n_out, 0);
    end
    pkt(32'h1234_5679, 8'h40, 16'h0000, 188);
    chk("drop", n_out, 0);
    pkt(ses_id, 8'h40, 16'h0000, 188, 13'h0100, 5'h02);
    chk("td", n_td, 1);
    chk("drop", n_out, 0);
    rreg(8'h10, 32'h0000_0008);
    rreg(8'h08, 32'h00c8_0007);
    wreg(8'h08, 32'h0000_0007);
    rreg(8'h08, 32'h00c8_0000);
  endtask
  task automatic t_udp;
    wreg(8'h00, 32'h0000_010f);
    pkt(ses_id, 8'h00, 16'h0000, 188, 13'h0100, 5'h01, 1'b1, 16'h7ff3);
    chk("udp", n_out, 188);
    pkt(ses_id, 8'h00, 16'h0000, 188, 13'h0100, 5'h01, 1'b1, 16'h8003);
    chk("udp", n_out, 0);
    pkt(ses_id, 8'h00, 16'h0000, 188, 13'h0100, 5'h01, 1'b1, 16'h0002);
    chk("udp", n_out, 0);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_fwd;
    t_null;
    t_seq;
    t_drop;
    t_udp;
    end_of_test;
  end
  // The run needs about 0.46 ms; five times that means a hang.
  initial begin
    #2.5ms;
    fail_count++;
    end_of_test;
  end
endmodule

// ===== hw/mpwdp_defs.vh
// Function
// R01: Transport-type bit must be zero; a set bit is not data and is dropped.
// R02: The eleven reserved bits after the transport-type bit are ignored.
// R03: Version field must read 3; anything else is dropped.
// R04: The sixteen-bit reserved field of the data header is ignored.
// R05: Session identifier must equal the configured session or the packet drops.
// R06: No cookie words; the data header layout is fixed.
// R07: In UDP mode the data header after the UDP header is parsed.
// R08: Wrong pseudowire type raises a teardown request for the session.
// R09: Non-conforming sublayer headers cause a silent drop.
// R10: Transport and multichannel payload segments are 188-byte packets.
// R11: Streaming mode segments carry frames or link channel data; not parsed here.
// R12: Connectivity-verification bit must be zero, else the packet drops.
// R13: Sequence numbers are checked only when the sequence-valid flag is set.
// R14: Extended-header bits must be 00 for forwarded data packets.
// R15: Reserved bit and reserved byte of the sublayer header are ignored.
// R16: Three-bit flow id; one configured flow is supported.
// R17: Consecutive sequence numbers must differ by one, else a loss is flagged.
// R18: Sender may start sequences anywhere; the first value is never checked.
// R19: One transport session per QAM channel; this block serves one session.
// R20: Sender inserts no filler; segments are taken back to back.
// R21: Payloads of one to seven packets are accepted, and more.
// R22: Larger payloads only with larger MTU; the parser has no upper limit.
// R23: Null packets with identifier 0x1FFF may be discarded.
// R24: Extended-header 01 is latency measurement; 10 and 11 are non-conforming.
// R25: Fields arrive most significant byte first, bits packed from the top.
`ifndef MPWDP_DEFS_VH
`define MPWDP_DEFS_VH
// Register offsets.
`define MPWDP_A_CTRL   8'h00
`define MPWDP_A_SESS   8'h04
`define MPWDP_A_STAT   8'h08
`define MPWDP_A_RXCNT  8'h0c
`define MPWDP_A_DRCNT  8'h10
`define MPWDP_A_LSCNT  8'h14
`define MPWDP_A_NLCNT  8'h18
// Control fields.
`define MPWDP_C_EN     0
`define MPWDP_C_UDP    1
`define MPWDP_C_SEQ    2
`define MPWDP_C_NULL   3
`define MPWDP_C_PWT    12:8
`define MPWDP_C_FLOW   18:16
// Status fields.
`define MPWDP_S_TD     0
`define MPWDP_S_LOSS   1
`define MPWDP_S_LEN    2
`define MPWDP_S_LAST   31:16
// Reset values.
`define MPWDP_CTRL_RST 32'h0000_010c
`define MPWDP_SESS_RST 32'h0000_0000
// Header layout.
`define MPWDP_VERSION  4'h3
`define MPWDP_HDR_END  5'h0b
`define MPWDP_SES_UDP  5'h0f
`define MPWDP_SES_IP   5'h03
`define MPWDP_SUB_UDP  5'h13
`define MPWDP_SUB_IP   5'h07
`define MPWDP_SEG_LAST 8'hbb
`define MPWDP_PID_POS  8'h02
`define MPWDP_NULL_PID 13'h1fff
`define MPWDP_FLUSH    2'h3
`endif

// ===== hw/mpwdp_parser.v
`timescale 1ns/1ps
`include "mpwdp_defs.vh"
module mpwdp_parser (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [7:0]  in_data,
  input  wire        in_sop,
  input  wire        in_eop,
  input  wire [4:0]  in_pw_type,
  output wire        out_valid,
  output wire [7:0]  out_data,
  output wire        out_sop,
  output wire        out_eop,
  output wire        teardown_req,
  output wire        seq_loss
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Packet states; the drain state holds the input off while the delay line empties.
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_HDR   = 3'h1;
  localparam [2:0] S_PAY   = 3'h2;
  localparam [2:0] S_DROP  = 3'h3;
  localparam [2:0] S_FLUSH = 3'h4;

  // Register file and bus read path.
  reg  [31:0] ctrl_q;
  reg  [31:0] sess_q;
  reg  [2:0]  stat_q;
  reg  [31:0] rx_cnt_q;
  reg  [31:0] dr_cnt_q;
  reg  [31:0] ls_cnt_q;
  reg  [31:0] nl_cnt_q;
  reg  [31:0] prdata_q;
  reg  [31:0] rd_d;
  reg         hit_d;
  // Parser state and one-cycle event pulses.
  reg  [2:0]  st_q;
  reg  [4:0]  hidx_q;
  reg  [23:0] hdr_q;
  reg         udp_q;
  reg  [7:0]  sidx_q;
  reg  [1:0]  fcnt_q;
  reg  [15:0] last_q;
  reg         seen_q;
  reg         segnul_q;
  reg         td_q;
  reg         loss_q;
  reg         drop_ev;
  reg         acc_ev;
  reg         len_ev;
  // Delay line and registered output stage.
  reg  [2:0]  p_v;
  reg  [2:0]  p_x;
  reg  [2:0]  p_s;
  reg  [2:0]  p_e;
  reg  [7:0]  p0;
  reg  [7:0]  p1;
  reg  [7:0]  p2;
  reg         ov_q;
  reg  [7:0]  od_q;
  reg         os_q;
  reg         oe_q;
  // Combinational decodes.
  wire        wr;
  wire        take;
  wire [31:0] w;
  wire [4:0]  ses_end;
  wire [4:0]  sub_end;
  wire        bad;
  wire        push;
  wire        shift;
  wire        nul_now;
  wire        seg_end;
  wire        bad_dh;
  wire        bad_ses;
  wire        bad_sub;
  wire        pid_pos;

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_d;
  assign prdata  = prdata_q;
  assign wr      = psel & penable & pwrite & hit_d;

  // Read mux and address decode; unmapped offsets read zero and error.
  always @* begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `MPWDP_A_CTRL:  rd_d = ctrl_q;
      `MPWDP_A_SESS:  rd_d = sess_q;
      `MPWDP_A_STAT:  rd_d = {last_q, 13'h0000, stat_q};
      `MPWDP_A_RXCNT: rd_d = rx_cnt_q;
      `MPWDP_A_DRCNT: rd_d = dr_cnt_q;
      `MPWDP_A_LSCNT: rd_d = ls_cnt_q;
      `MPWDP_A_NLCNT: rd_d = nl_cnt_q;
      default:        hit_d = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it stands in the access cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // Configuration registers.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `MPWDP_CTRL_RST;
      sess_q <= `MPWDP_SESS_RST;
    end else if (wr) begin
      if (paddr == `MPWDP_A_CTRL) begin
        ctrl_q <= pwdata;
      end
      if (paddr == `MPWDP_A_SESS) begin
        sess_q <= pwdata; // R05
      end
    end
  end

  // Write-one-to-clear strobe for one bit of the status register.
  function clr_hit;
    input       wr_i;
    input [7:0] addr_i;
    input       bit_i;
    begin
      clr_hit = wr_i & (addr_i == `MPWDP_A_STAT) & bit_i;
    end
  endfunction

  // Sticky status, write one to clear; a new event in the same cycle wins.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 3'h0;
    end else begin
      stat_q[`MPWDP_S_TD] <= td_q | (stat_q[`MPWDP_S_TD] &
        ~clr_hit(wr, paddr, pwdata[`MPWDP_S_TD]));
      stat_q[`MPWDP_S_LOSS] <= loss_q | (stat_q[`MPWDP_S_LOSS] &
        ~clr_hit(wr, paddr, pwdata[`MPWDP_S_LOSS]));
      stat_q[`MPWDP_S_LEN] <= len_ev | (stat_q[`MPWDP_S_LEN] &
        ~clr_hit(wr, paddr, pwdata[`MPWDP_S_LEN]));
    end
  end

  // Event counters, free running and wrapping; software takes differences.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_q <= 32'h0000_0000;
      dr_cnt_q <= 32'h0000_0000;
      ls_cnt_q <= 32'h0000_0000;
      nl_cnt_q <= 32'h0000_0000;
    end else begin
      if (acc_ev) begin
        rx_cnt_q <= rx_cnt_q + 32'h0000_0001;
      end
      if (drop_ev) begin
        dr_cnt_q <= dr_cnt_q + 32'h0000_0001;
      end
      if (loss_q) begin
        ls_cnt_q <= ls_cnt_q + 32'h0000_0001;
      end
      if (nul_now) begin
        nl_cnt_q <= nl_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Header parser
  // ****************************************************************

  // Input is only held off while the delay line drains after a packet.
  assign in_ready = (st_q != S_FLUSH);
  assign take     = in_valid & in_ready;
  assign w        = {hdr_q, in_data}; // R25
  assign ses_end  = udp_q ? `MPWDP_SES_UDP : `MPWDP_SES_IP; // R06
  assign sub_end  = udp_q ? `MPWDP_SUB_UDP : `MPWDP_SUB_IP; // R07

  // Data header word, UDP mode only: transport bit and version; X and reserved ignored.
  assign bad_dh  = udp_q & (hidx_q == `MPWDP_HDR_END) &
                   (w[31] | (w[19:16] != `MPWDP_VERSION)); // R01 R02 R03 R04
  // Session word: one session per channel, so one configured identifier.
  assign bad_ses = (hidx_q == ses_end) & (w != sess_q); // R05 R19
  // Sublayer word: V, H and flow are checked; X and the reserved byte are not.
  assign bad_sub = (hidx_q == sub_end) & (w[31] | (w[29:28] != 2'h0) | // R09 R12 R14 R24
                   (w[26:24] != ctrl_q[`MPWDP_C_FLOW])); // R15 R16
  // Any failed word sends the rest of the packet to the drop state.
  assign bad     = bad_dh | bad_ses | bad_sub;

  // Packet state machine with one-cycle event pulses.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= S_IDLE;
      hidx_q  <= 5'h00;
      hdr_q   <= 24'h00_0000;
      udp_q   <= 1'b0;
      sidx_q  <= 8'h00;
      fcnt_q  <= 2'h0;
      last_q  <= 16'h0000;
      seen_q  <= 1'b0;
      td_q    <= 1'b0;
      loss_q  <= 1'b0;
      drop_ev <= 1'b0;
      acc_ev  <= 1'b0;
      len_ev  <= 1'b0;
    end else begin
      // Event pulses default low, so each lasts exactly one cycle.
      td_q    <= 1'b0;
      loss_q  <= 1'b0;
      drop_ev <= 1'b0;
      acc_ev  <= 1'b0;
      len_ev  <= 1'b0;
      // A new session forgets the learned sequence number.
      if (wr & (paddr == `MPWDP_A_SESS)) begin
        seen_q <= 1'b0; // R18
      end
      case (st_q)
        // Only a start byte opens a packet; stray bytes between packets are ignored.
        S_IDLE: begin
          if (take & in_sop) begin
            hdr_q  <= {16'h0000, in_data};
            hidx_q <= 5'h01;
            udp_q  <= ctrl_q[`MPWDP_C_UDP];
            if (!ctrl_q[`MPWDP_C_EN]) begin
              drop_ev <= 1'b1;
              st_q    <= in_eop ? S_IDLE : S_DROP;
            end else if (in_pw_type != ctrl_q[`MPWDP_C_PWT]) begin
              // Another pseudowire type, streaming mode included, is torn down unparsed.
              td_q    <= 1'b1; // R08 R11
              drop_ev <= 1'b1;
              st_q    <= in_eop ? S_IDLE : S_DROP;
            end else if (in_eop) begin
              drop_ev <= 1'b1;
            end else begin
              st_q <= S_HDR;
            end
          end
        end
        // Header bytes shift into a word; each data header, session and sublayer word is checked as it completes.
        S_HDR: begin
          if (take) begin
            hdr_q  <= w[23:0];
            hidx_q <= hidx_q + 5'h01;
            if (bad | in_eop) begin
              drop_ev <= 1'b1; // R09
              len_ev  <= ~bad & in_eop & (hidx_q == sub_end);
              st_q    <= in_eop ? S_IDLE : S_DROP;
            end else if (hidx_q == sub_end) begin
              sidx_q <= 8'h00;
              st_q   <= S_PAY;
              if (w[30]) begin
                // The first sequence after a session change is only learned.
                loss_q <= ctrl_q[`MPWDP_C_SEQ] & seen_q &
                          (w[15:0] != last_q + 16'h0001); // R13 R17 R18
                last_q <= w[15:0];
                seen_q <= 1'b1;
              end
            end
          end
        end
        // Payload bytes are counted into 188-byte segments, back to back.
        S_PAY: begin
          if (take) begin
            sidx_q <= seg_end ? 8'h00 : sidx_q + 8'h01; // R10 R20
            if (in_eop) begin
              st_q   <= S_FLUSH;
              fcnt_q <= `MPWDP_FLUSH;
              acc_ev <= seg_end; // R21 R22
              len_ev <= ~seg_end; // R10
            end
          end
        end
        // The rest of a dropped packet is swallowed up to its end byte.
        S_DROP: begin
          if (take & in_eop) begin
            st_q <= S_IDLE;
          end
        end
        // Input is held off while the last three bytes leave the delay line.
        S_FLUSH: begin
          fcnt_q <= fcnt_q - 2'h1;
          if (fcnt_q == 2'h1) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Payload delay line and null filter
  // ****************************************************************

  // Three bytes of delay let the packet identifier in bytes 1 and 2 decide
  // the fate of a whole segment before its first byte leaves the block.
  assign seg_end = (sidx_q == `MPWDP_SEG_LAST);
  assign push    = (st_q == S_PAY) & take;
  assign shift   = push | (st_q == S_FLUSH);
  // The byte at this position completes the packet identifier of a segment.
  assign pid_pos = (sidx_q == `MPWDP_PID_POS);
  assign nul_now = push & pid_pos & ctrl_q[`MPWDP_C_NULL] &
                   ({p0[4:0], in_data} == `MPWDP_NULL_PID); // R23

  // Shift on every payload byte and on each drain cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p_v      <= 3'h0;
      p_x      <= 3'h0;
      p_s      <= 3'h0;
      p_e      <= 3'h0;
      p0       <= 8'h00;
      p1       <= 8'h00;
      p2       <= 8'h00;
      segnul_q <= 1'b0;
    end else if (shift) begin
      p_v <= {p_v[1:0], push};
      p_s <= {p_s[1:0], push & (sidx_q == 8'h00)};
      p_e <= {p_e[1:0], push & (seg_end | in_eop)};
      p2  <= p1;
      p1  <= p0;
      p0  <= push ? in_data : 8'h00;
      // A null verdict also marks the two earlier bytes of its segment.
      p_x[2] <= p_x[1] | nul_now; // R23
      p_x[1] <= p_x[0] | nul_now;
      p_x[0] <= pid_pos ? nul_now : ((sidx_q > `MPWDP_PID_POS) & segnul_q);
      // The verdict stays for the remaining bytes of the segment.
      if (push & pid_pos) begin
        segnul_q <= nul_now;
      end
    end
  end

  // Registered output stream; a short tail segment still ends with eop.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_q <= 1'b0;
      od_q <= 8'h00;
      os_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      ov_q <= shift & p_v[2] & ~p_x[2];
      od_q <= p2;
      os_q <= shift & p_s[2];
      oe_q <= shift & p_e[2];
    end
  end

  // Start and end marks only count on forwarded bytes.
  assign out_valid    = ov_q;
  assign out_data     = od_q;
  assign out_sop      = os_q & ov_q;
  assign out_eop      = oe_q & ov_q;
  assign teardown_req = td_q;
  assign seq_loss     = loss_q;

endmodule
